// file: rtl/rtc_requester_tag_credit_tracker.sv
// requester-side tag allocation, outstanding table, credit and order reporting
// assumes request stream, completions and credit returns all on CLK
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module rtc_requester_tag_credit_tracker
	import rtc_pkg::*;
#(
	parameter int unsigned PAYLOAD_W = 512,
	parameter int unsigned MAX_OUTSTANDING = 768
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// apb register port
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// request stream from user logic
	input wire logic REQUEST_STREAM_VALID,
	input wire logic [PAYLOAD_W-1:0] REQUEST_STREAM_PAYLOAD,
	input wire rtc_sideband_type REQUEST_STREAM_SIDEBAND,
	output logic REQUEST_STREAM_READY,
	// allocated tag report
	output logic ALLOCATED_TAG_VALID_A,
	output logic ALLOCATED_TAG_VALID_B,
	output logic [TAG_W-1:0] ALLOCATED_TAG_LANE_A,
	output logic [TAG_W-1:0] ALLOCATED_TAG_LANE_B,
	// availability counts
	output logic [AVAIL_W-1:0] NP_HEADER_CREDIT_COUNT,
	output logic [AVAIL_W-1:0] NP_DATA_CREDIT_COUNT,
	output logic [AVAIL_W-1:0] FREE_TAG_COUNT,
	// posted order report
	output logic POSTED_ORDER_VALID_A,
	output logic POSTED_ORDER_VALID_B,
	output logic [SEQ_W-1:0] POSTED_ORDER_ID_OUT_A,
	output logic [SEQ_W-1:0] POSTED_ORDER_ID_OUT_B,
	// flow-control configuration view
	output logic [NPH_W-1:0] FLOWCTL_NP_HEADER_VIEW,
	output logic [NPD_W-1:0] FLOWCTL_NP_DATA_VIEW,
	// toward the link
	output logic LINK_TX_VALID,
	output logic [PAYLOAD_W-1:0] LINK_TX_PAYLOAD,
	// returns from the link
	input wire logic CPL_VALID,
	input wire logic [TAG_W-1:0] CPL_TAG,
	input wire logic CPL_FINAL,
	input wire logic [3:0] CREDIT_RETURN_NPH,
	input wire logic [7:0] CREDIT_RETURN_NPD
);

	typedef struct packed {
		logic [TAG_SPACE-1:0] busy;
		logic [OUT_CNT_W-1:0] out_cnt;
		logic [NPH_W-1:0] nph;
		logic [NPD_W-1:0] npd;
		logic internal_tags;
		logic straddle_en;
		logic [1:0] tag_size;
		logic [FC_SEL_W-1:0] flowctl_view_select;
		logic [AVAIL_W-1:0] nph_av;
		logic [AVAIL_W-1:0] npd_av;
		logic [AVAIL_W-1:0] tag_av;
		logic [NPH_W-1:0] fc_hdr;
		logic [NPD_W-1:0] fc_data;
		rtc_stage_type [PIPE_STAGES-1:0] pipe;
		logic [PIPE_STAGES-1:0][PAYLOAD_W-1:0] payload;
		logic [31:0] prdata;
	} rtc_state_type;

	localparam logic [OUT_CNT_W-1:0] MAX_OUT = OUT_CNT_W'(MAX_OUTSTANDING);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [AVAIL_W-1:0] sat4(input logic [NPD_W-1:0] v);
		sat4 = (v > NPD_W'(15)) ? 4'hf : v[AVAIL_W-1:0];
	endfunction

	function automatic logic [OUT_CNT_W-1:0] tag_space_of(input logic [1:0] sz);
		case (sz)
			TAG_SIZE_5: tag_space_of = 11'h020;
			TAG_SIZE_8: tag_space_of = 11'h100;
			default: tag_space_of = 11'h400;
		endcase
	endfunction

	// lowest free tag below space, optionally skipping one already chosen
	function automatic logic [TAG_W:0] find_free(input logic [TAG_SPACE-1:0] busy,
			input logic [OUT_CNT_W-1:0] space, input logic [TAG_W-1:0] skip,
			input logic use_skip);
		logic [TAG_W:0] r;
		r = '0;
		for (int i = TAG_SPACE - 1; i >= 0; i--) begin
			if ((OUT_CNT_W'(i) < space) && !busy[i] &&
					!(use_skip && (skip == TAG_W'(i)))) begin
				r = {1'b1, TAG_W'(i)};
			end
		end
		find_free = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	rtc_state_type s_q;
	rtc_state_type s_d;
	logic ready;
	logic access_ok;

	always_comb begin
		rtc_sideband_type sb;
		logic [1:0] starts;
		logic [1:0] np;
		logic [1:0] po;
		logic [OUT_CNT_W-1:0] space;
		logic [OUT_CNT_W-1:0] limit;
		logic [TAG_W:0] fa;
		logic [TAG_W:0] fb;
		logic [1:0] np_cnt;
		logic [4:0] need_npd;
		logic blocked;
		logic accept;
		logic [TAG_W-1:0] tag_for_a;
		logic [TAG_W-1:0] tag_for_b;
		logic freed;
		logic [NPH_W:0] nph_w;
		logic [NPD_W:0] npd_w;
		rtc_stage_type st;
		sb = REQUEST_STREAM_SIDEBAND;
		starts = '0;
		np = '0;
		po = '0;
		space = '0;
		limit = '0;
		fa = '0;
		fb = '0;
		np_cnt = '0;
		need_npd = '0;
		blocked = 1'b0;
		accept = 1'b0;
		tag_for_a = '0;
		tag_for_b = '0;
		freed = 1'b0;
		nph_w = '0;
		npd_w = '0;
		st = '0;
		s_d = s_q;

		// a second start in the beat only exists with straddle on
		starts = sb.packet_start_flags;
		if (!s_q.straddle_en) begin
			starts[1] = 1'b0;
		end
		np = starts & sb.nonposted;
		po = starts & ~sb.nonposted;

		space = tag_space_of(s_q.tag_size);
		limit = (space < MAX_OUT) ? space : MAX_OUT;
		fa = find_free(s_q.busy, space, '0, 1'b0);
		fb = find_free(s_q.busy, space, fa[TAG_W-1:0], 1'b1);

		np_cnt = 2'({1'b0, np[0]} + {1'b0, np[1]});
		need_npd = 5'((np[0] ? {1'b0, sb.data_credit_a} : 5'h00) +
			(np[1] ? {1'b0, sb.data_credit_b} : 5'h00));

		// credit shortage holds a request in either tag mode
		blocked = (s_q.nph < NPH_W'(np_cnt)) || (s_q.npd < NPD_W'(need_npd));
		if (s_q.internal_tags) begin
			// external mode skips these checks entirely
			if ((s_q.out_cnt + OUT_CNT_W'(np_cnt)) > limit) begin
				blocked = 1'b1;
			end
			if ((np_cnt != 2'h0 && !fa[TAG_W]) || (np_cnt == 2'h2 && !fb[TAG_W])) begin
				blocked = 1'b1;
			end
		end
		ready = (np == 2'b00) || !blocked;
		accept = REQUEST_STREAM_VALID && ready;

		// final completions free their tag; a fresh record of the same tag below wins
		if (CPL_VALID && CPL_FINAL && s_q.busy[CPL_TAG]) begin
			s_d.busy[CPL_TAG] = 1'b0;
			freed = 1'b1;
		end

		// lane b takes the next free tag only if lane a also needed one
		tag_for_a = s_q.internal_tags ? fa[TAG_W-1:0] : sb.ext_tag_a;
		tag_for_b = s_q.internal_tags ? (np[0] ? fb[TAG_W-1:0] : fa[TAG_W-1:0])
			: sb.ext_tag_b;

		if (accept) begin
			st.tx_vld = 1'b1;
			if (np[0]) begin
				s_d.busy[tag_for_a] = 1'b1;
			end
			if (np[1]) begin
				s_d.busy[tag_for_b] = 1'b1;
			end
			if (s_q.internal_tags) begin
				if (np[0]) begin
					st.tag_vld_a = 1'b1;
					st.tag_a = tag_for_a;
				end
				if (np[1] && np[0]) begin
					st.tag_vld_b = 1'b1;
					st.tag_b = tag_for_b;
				end else if (np[1]) begin
					st.tag_vld_a = 1'b1;
					st.tag_a = tag_for_b;
				end
			end
			if (po[0]) begin
				st.ord_vld_a = 1'b1;
				st.ord_a = sb.posted_order_id_in_a;
			end
			if (po[1] && po[0]) begin
				st.ord_vld_b = 1'b1;
				st.ord_b = sb.posted_order_id_in_b;
			end else if (po[1]) begin
				st.ord_vld_a = 1'b1;
				st.ord_a = sb.posted_order_id_in_b;
			end
		end

		// fixed-depth shift keeps report order equal to acceptance order
		for (int k = PIPE_STAGES - 1; k > 0; k--) begin
			s_d.pipe[k] = s_q.pipe[k-1];
			s_d.payload[k] = s_q.payload[k-1];
		end
		s_d.pipe[0] = st;
		s_d.payload[0] = accept ? REQUEST_STREAM_PAYLOAD : s_q.payload[0];

		s_d.out_cnt = s_q.out_cnt + OUT_CNT_W'(accept ? np_cnt : 2'h0)
			- OUT_CNT_W'(freed);

		// returns saturate; taking never underflows because blocked covers it
		nph_w = {1'b0, s_q.nph} + (NPH_W + 1)'(CREDIT_RETURN_NPH)
			- (NPH_W + 1)'(accept ? np_cnt : 2'h0);
		npd_w = {1'b0, s_q.npd} + (NPD_W + 1)'(CREDIT_RETURN_NPD)
			- (NPD_W + 1)'(accept ? need_npd : 5'h00);
		s_d.nph = nph_w[NPH_W] ? {NPH_W{1'b1}} : nph_w[NPH_W-1:0];
		s_d.npd = npd_w[NPD_W] ? {NPD_W{1'b1}} : npd_w[NPD_W-1:0];

		// counts were updated at the accepting edge, one more stage gives two
		s_d.nph_av = sat4(NPD_W'(s_q.nph));
		s_d.npd_av = sat4(s_q.npd);
		s_d.tag_av = sat4(NPD_W'(limit - s_q.out_cnt));

		if (s_q.flowctl_view_select == FC_SEL_TX_AVAIL) begin
			s_d.fc_hdr = s_q.nph;
			s_d.fc_data = s_q.npd;
		end else begin
			s_d.fc_hdr = '0;
			s_d.fc_data = '0;
		end

		// apb: read data captured in setup, writes take effect in access
		if (PSEL && !PENABLE) begin
			case (PADDR)
				ADDR_CTRL: s_d.prdata = {25'h0000000, s_q.flowctl_view_select,
					s_q.tag_size, s_q.straddle_en, s_q.internal_tags};
				ADDR_CREDIT: s_d.prdata = {12'h000, s_q.npd, s_q.nph};
				ADDR_STATUS: s_d.prdata = {21'h000000, s_q.out_cnt};
				default: s_d.prdata = '0;
			endcase
		end
		if (PSEL && PENABLE && PWRITE) begin
			case (PADDR)
				ADDR_CTRL: begin
					s_d.internal_tags = PWDATA[CTRL_INT_TAG_BIT];
					s_d.straddle_en = PWDATA[CTRL_STRADDLE_BIT];
					s_d.tag_size = PWDATA[CTRL_TAG_SIZE_LSB +: 2];
					s_d.flowctl_view_select = PWDATA[CTRL_FC_SEL_LSB +: FC_SEL_W];
				end
				ADDR_CREDIT: begin
					s_d.nph = PWDATA[CREDIT_NPH_LSB +: NPH_W];
					s_d.npd = PWDATA[CREDIT_NPD_LSB +: NPD_W];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_q <= '0;
			s_q.internal_tags <= CTRL_INT_TAG_RST;
			s_q.straddle_en <= CTRL_STRADDLE_RST;
			s_q.tag_size <= CTRL_TAG_SIZE_RST;
			s_q.flowctl_view_select <= FC_SEL_RST;
			s_q.nph <= NPH_RESET;
			s_q.npd <= NPD_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign access_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_CREDIT) ||
		(PADDR == ADDR_STATUS);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !access_ok;
	assign PRDATA = s_q.prdata;
	assign REQUEST_STREAM_READY = ready;

	assign ALLOCATED_TAG_VALID_A = s_q.pipe[PIPE_STAGES-1].tag_vld_a;
	assign ALLOCATED_TAG_VALID_B = s_q.pipe[PIPE_STAGES-1].tag_vld_b;
	assign ALLOCATED_TAG_LANE_A = s_q.pipe[PIPE_STAGES-1].tag_a;
	assign ALLOCATED_TAG_LANE_B = s_q.pipe[PIPE_STAGES-1].tag_b;

	assign NP_HEADER_CREDIT_COUNT = s_q.nph_av;
	assign NP_DATA_CREDIT_COUNT = s_q.npd_av;
	assign FREE_TAG_COUNT = s_q.tag_av;

	// order ids leave in the same cycle as their request, so nothing sent later passes
	assign POSTED_ORDER_VALID_A = s_q.pipe[PIPE_STAGES-1].ord_vld_a;
	assign POSTED_ORDER_VALID_B = s_q.pipe[PIPE_STAGES-1].ord_vld_b;
	assign POSTED_ORDER_ID_OUT_A = s_q.pipe[PIPE_STAGES-1].ord_a;
	assign POSTED_ORDER_ID_OUT_B = s_q.pipe[PIPE_STAGES-1].ord_b;

	assign FLOWCTL_NP_HEADER_VIEW = s_q.fc_hdr;
	assign FLOWCTL_NP_DATA_VIEW = s_q.fc_data;

	assign LINK_TX_VALID = s_q.pipe[PIPE_STAGES-1].tx_vld;
	assign LINK_TX_PAYLOAD = s_q.payload[PIPE_STAGES-1];

endmodule

// file: shared/rtc_pkg.sv
// shared constants and carriers for the requester tag and credit tracker
// assumes one user clock and a 32-bit apb register port
package rtc_pkg;

	// widths
	localparam int unsigned TAG_W = 10;
	localparam int unsigned TAG_SPACE = 1024;
	localparam int unsigned OUT_CNT_W = 11;
	localparam int unsigned NPH_W = 8;
	localparam int unsigned NPD_W = 12;
	localparam int unsigned AVAIL_W = 4;
	localparam int unsigned SEQ_W = 6;
	localparam int unsigned FC_SEL_W = 3;
	localparam int unsigned ADDR_W = 12;

	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_CREDIT = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;

	// field positions
	localparam int unsigned CTRL_INT_TAG_BIT = 0;
	localparam int unsigned CTRL_STRADDLE_BIT = 1;
	localparam int unsigned CTRL_TAG_SIZE_LSB = 2;
	localparam int unsigned CTRL_FC_SEL_LSB = 4;
	localparam int unsigned CREDIT_NPH_LSB = 0;
	localparam int unsigned CREDIT_NPD_LSB = 8;

	// values after reset
	localparam logic CTRL_INT_TAG_RST = 1'b1;
	localparam logic CTRL_STRADDLE_RST = 1'b1;
	localparam logic [1:0] CTRL_TAG_SIZE_RST = 2'h2;
	localparam logic [FC_SEL_W-1:0] FC_SEL_RST = 3'h0;
	localparam logic [NPH_W-1:0] NPH_RESET = 8'h10;
	localparam logic [NPD_W-1:0] NPD_RESET = 12'h040;

	// encodings
	localparam logic [1:0] TAG_SIZE_5 = 2'h0;
	localparam logic [1:0] TAG_SIZE_8 = 2'h1;
	localparam logic [FC_SEL_W-1:0] FC_SEL_TX_AVAIL = 3'h4;

	// cycles from accept to tag, order and transmit report
	localparam int unsigned PIPE_STAGES = 2;

	// per-beat request sideband, lane a is the first packet starting in the beat
	typedef struct packed {
		logic [1:0] packet_start_flags;
		logic [1:0] nonposted;
		logic [3:0] data_credit_a;
		logic [3:0] data_credit_b;
		logic [TAG_W-1:0] ext_tag_a;
		logic [TAG_W-1:0] ext_tag_b;
		logic [SEQ_W-1:0] posted_order_id_in_a;
		logic [SEQ_W-1:0] posted_order_id_in_b;
	} rtc_sideband_type;

	// one transmit pipeline stage
	typedef struct packed {
		logic tag_vld_a;
		logic tag_vld_b;
		logic [TAG_W-1:0] tag_a;
		logic [TAG_W-1:0] tag_b;
		logic ord_vld_a;
		logic ord_vld_b;
		logic [SEQ_W-1:0] ord_a;
		logic [SEQ_W-1:0] ord_b;
		logic tx_vld;
	} rtc_stage_type;

endpackage

// file: verif/rtc_requester_tag_credit_tracker_tb.sv
// self-checking bench for the tag and credit tracker with a four-entry table
// assumes the user model on the request stream and apb tasks here
`timescale 1ns/1ps
module rtc_requester_tag_credit_tracker_tb;
	import rtc_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, rs_valid, rs_ready;
	logic tv_a, tv_b, ov_a, ov_b, cpl_valid, cpl_final;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [511:0] rs_payload;
	rtc_sideband_type rs_sb;
	logic [TAG_W-1:0] tag_a, tag_b, cpl_tag;
	logic [3:0] nph_cnt, npd_cnt, free_cnt, ret_nph;
	logic [SEQ_W-1:0] oid_a, oid_b;
	logic [NPH_W-1:0] fc_h;
	logic [NPD_W-1:0] fc_d;
	logic [7:0] ret_npd;
	logic err;
	int failures = 0;
	int checks_done = 0;
	rtc_requester_tag_credit_tracker #(.PAYLOAD_W(512), .MAX_OUTSTANDING(4)) i_dut (
		.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.REQUEST_STREAM_VALID(rs_valid), .REQUEST_STREAM_PAYLOAD(rs_payload),
		.REQUEST_STREAM_SIDEBAND(rs_sb), .REQUEST_STREAM_READY(rs_ready),
		.ALLOCATED_TAG_VALID_A(tv_a), .ALLOCATED_TAG_VALID_B(tv_b),
		.ALLOCATED_TAG_LANE_A(tag_a), .ALLOCATED_TAG_LANE_B(tag_b),
		.NP_HEADER_CREDIT_COUNT(nph_cnt), .NP_DATA_CREDIT_COUNT(npd_cnt), .FREE_TAG_COUNT(free_cnt),
		.POSTED_ORDER_VALID_A(ov_a), .POSTED_ORDER_VALID_B(ov_b),
		.POSTED_ORDER_ID_OUT_A(oid_a), .POSTED_ORDER_ID_OUT_B(oid_b),
		.FLOWCTL_NP_HEADER_VIEW(fc_h), .FLOWCTL_NP_DATA_VIEW(fc_d),
		.LINK_TX_VALID(), .LINK_TX_PAYLOAD(), .CPL_VALID(cpl_valid), .CPL_TAG(cpl_tag),
		.CPL_FINAL(cpl_final), .CREDIT_RETURN_NPH(ret_nph), .CREDIT_RETURN_NPD(ret_npd)
	);
	rtc_user_model #(.PAYLOAD_W(512)) u (
		.clk(clk), .valid(rs_valid), .payload(rs_payload), .sideband(rs_sb), .ready(rs_ready),
		.tag_vld_a(tv_a), .tag_vld_b(tv_b), .tag_a(tag_a), .tag_b(tag_b),
		.ord_vld_a(ov_a), .ord_vld_b(ov_b), .ord_a(oid_a), .ord_b(oid_b)
	);
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		logic rdy;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			rdy = pready;
			rd = prdata;
			err = pslverr;
		end while (!rdy);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cpl(input logic [TAG_W-1:0] t);
		@(posedge clk);
		cpl_valid <= 1'b1;
		cpl_tag <= t;
		@(posedge clk);
		cpl_valid <= 1'b0;
	endtask
	function automatic rtc_sideband_type req(input logic [1:0] st, np, input logic [9:0] et,
		input logic [5:0] ia, ib);
		return '{st, np, 4'h1, 4'h0, et, et + 10'h1, ia, ib};
	endfunction
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		conclude();
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, cpl_valid, cpl_tag, ret_nph, ret_npd} = '0;
		rst = 1'b1;
		cpl_final = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check("free tags", 4, free_cnt);
		check("header count", 15, nph_cnt);
		check("data count", 15, npd_cnt);
		apb(0, ADDR_CTRL, 0);
		check("ctrl", 32'h0000000b, rd);
		apb(0, 12'h00c, 0);
		check("unmapped error", 1, err);
		apb(1, ADDR_CTRL, 32'h0000004b);
		apb(1, ADDR_CREDIT, 32'h00000502);
		repeat (3) @(posedge clk);
		#1;
		check("fc header view", 2, fc_h);
		check("fc data view", 5, fc_d);
		check("header count", 2, nph_cnt);
		check("data count", 5, npd_cnt);
		u.send(req(2'h3, 2'h3, 0, 0, 0));
		#1;
		check("free tags early", 4, free_cnt);
		@(posedge clk);
		#1;
		check("free tags lag", 2, free_cnt);
		check("header spent", 0, nph_cnt);
		// tags are kept by the model one edge after the report stands
		@(posedge clk);
		#1;
		check("first tag", 0, u.tags[0]);
		check("second tag", 1, u.tags[1]);
		fork
			u.send(req(2'h1, 2'h1, 0, 0, 0));
			begin
				repeat (4) @(posedge clk);
				#1;
				check("held for credit", 0, rs_ready);
				@(posedge clk) ret_nph <= 4'h1;
				@(posedge clk) ret_nph <= 4'h0;
			end
		join
		cpl(0);
		repeat (3) @(posedge clk);
		#1;
		check("fifo tag", 2, u.tags[2]);
		check("freed tag", 2, free_cnt);
		apb(1, ADDR_CREDIT, 32'h00004010);
		u.send(req(2'h1, 2'h1, 0, 0, 0));
		u.send(req(2'h1, 2'h1, 0, 0, 0));
		fork
			u.send(req(2'h1, 2'h1, 10'h3f0, 0, 0));
			begin
				repeat (4) @(posedge clk);
				#1;
				check("table full", 0, rs_ready);
				check("no free tag", 0, free_cnt);
				apb(1, ADDR_CTRL, 32'h0000004a);
			end
		join
		repeat (3) @(posedge clk);
		check("lowest free", 0, u.tags[3]);
		check("next free", 3, u.tags[4]);
		check("external no tag", 5, u.tags.size());
		u.send(req(2'h3, 2'h0, 0, 6'h05, 6'h09));
		repeat (3) @(posedge clk);
		#1;
		check("order a", 6'h05, u.ids[0]);
		check("order b", 6'h09, u.ids[1]);
		cpl(1);
		cpl(2);
		apb(1, ADDR_CTRL, 32'h00000049);
		u.send(req(2'h3, 2'h3, 0, 0, 0));
		repeat (3) @(posedge clk);
		#1;
		check("single lane tags", 6, u.tags.size());
		check("single lane tag", 1, u.tags[5]);
		apb(0, ADDR_STATUS, 0);
		check("outstanding", 4, rd);
		conclude();
	end
endmodule

// file: verif/rtc_tracker_chk.sv
// checker for the tracker's request stream and its tag and order reports
// assumes it is bound into the tracker and sees only the tracker's ports
`timescale 1ns/1ps
module rtc_tracker_chk
	import rtc_pkg::*;
#(
	parameter int unsigned PAYLOAD_W = 512
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// request stream
	input wire logic REQUEST_STREAM_VALID,
	input wire logic REQUEST_STREAM_READY,
	input wire rtc_sideband_type REQUEST_STREAM_SIDEBAND,
	input wire logic [PAYLOAD_W-1:0] REQUEST_STREAM_PAYLOAD,
	// reports
	input wire logic ALLOCATED_TAG_VALID_A,
	input wire logic ALLOCATED_TAG_VALID_B,
	input wire logic [TAG_W-1:0] ALLOCATED_TAG_LANE_A,
	input wire logic [TAG_W-1:0] ALLOCATED_TAG_LANE_B,
	input wire logic POSTED_ORDER_VALID_A,
	input wire logic POSTED_ORDER_VALID_B,
	input wire logic [SEQ_W-1:0] POSTED_ORDER_ID_OUT_A,
	input wire logic LINK_TX_VALID,
	input wire logic [PAYLOAD_W-1:0] LINK_TX_PAYLOAD
);
	logic take_w;
	logic [1:0] np_w;
	assign take_w = REQUEST_STREAM_VALID && REQUEST_STREAM_READY;
	assign np_w = REQUEST_STREAM_SIDEBAND.packet_start_flags & REQUEST_STREAM_SIDEBAND.nonposted;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence take_s;
		take_w;
	endsequence
	sequence posted_a_s;
		take_s ##0 (REQUEST_STREAM_SIDEBAND.packet_start_flags[0] && !np_w[0]);
	endsequence
	////////////////////////////////////////////////////////////////
	link_order_a: assert property (take_s |-> ##2 (LINK_TX_VALID &&
		LINK_TX_PAYLOAD == $past(REQUEST_STREAM_PAYLOAD, 2)))
		else $error("accepted beat not sent two cycles later");
	tag_cause_a: assert property (ALLOCATED_TAG_VALID_A |-> $past(take_w && np_w != 2'h0, 2))
		else $error("tag reported without a non-posted request");
	tag_pulse_a: assert property (ALLOCATED_TAG_VALID_A && !$past(take_w) |=> !ALLOCATED_TAG_VALID_A)
		else $error("tag valid outlasts its request");
	pair_cause_a: assert property (ALLOCATED_TAG_VALID_B |-> $past(take_w && np_w == 2'h3, 2))
		else $error("second tag without two requests");
	lane_b_pair_a: assert property (ALLOCATED_TAG_VALID_B |->
		ALLOCATED_TAG_VALID_A && ALLOCATED_TAG_LANE_A < ALLOCATED_TAG_LANE_B)
		else $error("second tag lane alone or out of order");
	order_pair_a: assert property (POSTED_ORDER_VALID_B |-> POSTED_ORDER_VALID_A)
		else $error("second order valid without the first");
	order_report_a: assert property (posted_a_s |-> ##2 (POSTED_ORDER_VALID_A &&
		POSTED_ORDER_ID_OUT_A == $past(REQUEST_STREAM_SIDEBAND.posted_order_id_in_a, 2)))
		else $error("posted order id not reported");
	reset_quiet_a: assert property (disable iff (1'b0) RST |=>
		!ALLOCATED_TAG_VALID_A && !ALLOCATED_TAG_VALID_B && !POSTED_ORDER_VALID_A)
		else $error("report valid right after reset");
endmodule

bind rtc_requester_tag_credit_tracker rtc_tracker_chk #(.PAYLOAD_W(PAYLOAD_W)) i_chk (
	.CLK(CLK), .RST(RST), .REQUEST_STREAM_VALID(REQUEST_STREAM_VALID),
	.REQUEST_STREAM_READY(REQUEST_STREAM_READY), .REQUEST_STREAM_SIDEBAND(REQUEST_STREAM_SIDEBAND),
	.ALLOCATED_TAG_VALID_A(ALLOCATED_TAG_VALID_A), .ALLOCATED_TAG_VALID_B(ALLOCATED_TAG_VALID_B),
	.ALLOCATED_TAG_LANE_A(ALLOCATED_TAG_LANE_A), .ALLOCATED_TAG_LANE_B(ALLOCATED_TAG_LANE_B),
	.POSTED_ORDER_VALID_A(POSTED_ORDER_VALID_A), .POSTED_ORDER_VALID_B(POSTED_ORDER_VALID_B),
	.POSTED_ORDER_ID_OUT_A(POSTED_ORDER_ID_OUT_A), .LINK_TX_VALID(LINK_TX_VALID),
	.REQUEST_STREAM_PAYLOAD(REQUEST_STREAM_PAYLOAD), .LINK_TX_PAYLOAD(LINK_TX_PAYLOAD)
);

// file: verif/rtc_user_model.sv
// user logic issuing requests and keeping the reported tags and order ids
// assumes the bench calls send and reads the kept queues
`timescale 1ns/1ps
module rtc_user_model
	import rtc_pkg::*;
#(
	parameter int unsigned PAYLOAD_W = 512
) (
	// clock
	input wire logic clk,
	// request stream
	output logic valid,
	output logic [PAYLOAD_W-1:0] payload,
	output rtc_sideband_type sideband,
	input wire logic ready,
	// reports
	input wire logic tag_vld_a,
	input wire logic tag_vld_b,
	input wire logic [TAG_W-1:0] tag_a,
	input wire logic [TAG_W-1:0] tag_b,
	input wire logic ord_vld_a,
	input wire logic ord_vld_b,
	input wire logic [SEQ_W-1:0] ord_a,
	input wire logic [SEQ_W-1:0] ord_b
);
	logic [TAG_W-1:0] tags[$];
	logic [SEQ_W-1:0] ids[$];
	initial begin
		valid = 1'b0;
		payload = '0;
		sideband = '0;
	end
	// kept in report order so later completions can be matched
	always @(posedge clk) begin
		if (tag_vld_a) tags.push_back(tag_a);
		if (tag_vld_b) tags.push_back(tag_b);
		if (ord_vld_a) ids.push_back(ord_a);
		if (ord_vld_b) ids.push_back(ord_b);
	end
	// ready is taken at the rising edge that accepts the beat, before the design updates
	task automatic send(input rtc_sideband_type sb);
		logic rdy;
		@(posedge clk);
		valid <= 1'b1;
		sideband <= sb;
		payload <= PAYLOAD_W'(sb);
		do begin
			@(posedge clk);
			rdy = ready;
		end while (!rdy);
		valid <= 1'b0;
		sideband <= ~sb;
		payload <= ~PAYLOAD_W'(sb);
	endtask
endmodule
